// ### hdl/scs_pkg.sv
package scs_pkg;

	// =============================================================
	// register map (byte addresses on the 32-bit bus)
	localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
	localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
	localparam logic [31:0] ADDR_MASK   = 32'h0000_0008;
	localparam logic [31:0] ADDR_STATE  = 32'h0000_000C;

	localparam logic [1:0]  HTRANS_IDLE = 2'h0;
	localparam logic        HRESP_OKAY  = 1'b0;
	localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;

	// =============================================================
	// sleep kind codes
	localparam logic [1:0] KIND_IDLE  = 2'h0;
	localparam logic [1:0] KIND_UNDEF = 2'h1;
	localparam logic [1:0] KIND_DOWN  = 2'h2;
	localparam logic [1:0] KIND_SAVE  = 2'h3;

	// =============================================================
	// timing
	localparam int unsigned CLK_NS    = 100;
	localparam int unsigned NS_PER_US = 1000;
	localparam int unsigned DELAY_W   = 24;
	localparam logic [1:0]  SETTLE_EXT_CYC   = 2'h2;
	localparam logic [1:0]  SETTLE_TIMER_CYC = 2'h3;
	localparam logic [1:0]  SETTLE_ONE       = 2'h1;
	localparam logic [DELAY_W-1:0] DELAY_ONE = 24'h00_0001;

	// =============================================================
	// types
	typedef enum logic [2:0] {
		MODE_RUN,
		MODE_IDLE,
		MODE_DOWN,
		MODE_RESTART,
		MODE_SETTLE
	} scs_mode_type;

	typedef enum logic [1:0] {
		CAUSE_NONE,
		CAUSE_LEVEL,
		CAUSE_TIMER,
		CAUSE_RESET
	} scs_cause_type;

	typedef struct packed {
		logic [1:0] startup_time_fuses;
		logic       t0_cmp_irq_en;
		logic       t0_ovf_irq_en;
		logic       timer0_external_osc_select;
		logic       sleep_kind_select_hi;
		logic       sleep_kind_select_lo;
		logic       sleep_permit_bit;
	} scs_ctrl_type;

	typedef struct packed {
		logic reset_wake;
		logic wake_dropped;
		logic woke;
		logic slept;
	} scs_event_type;

	localparam scs_ctrl_type  CTRL_RESET  = '0;
	localparam scs_event_type EVENT_NONE  = '0;

	typedef struct packed {
		scs_mode_type       mode;
		scs_cause_type      cause;
		logic               saving;
		logic               level_lost;
		logic [DELAY_W-1:0] dly;
		logic [1:0]         settle;
		scs_ctrl_type       ctrl;
		scs_event_type      status;
		scs_event_type      mask;
		logic               a_valid;
		logic               a_write;
		logic [31:0]        a_addr;
		logic [31:0]        rdata;
		logic               resume;
		logic               vector;
		logic               discard;
	} scs_state_type;

	typedef struct packed {
		logic first;
		logic confirmed;
	} scs_sample_type;

endpackage

// ### hdl/scs_level_sampler.sv
`timescale 1ns/1ps
module scs_level_sampler
	import scs_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic armed,
	input  wire logic level,
	input  wire logic tick,
	output      logic confirmed
);

	scs_sample_type s_q;
	scs_sample_type s_d;

	// =============================================================
	// two samples on the watchdog oscillator tick
	always_comb begin
		s_d = s_q;
		if (!armed) begin
			s_d = '0;
		end else if (tick) begin
			s_d.first     = level;
			s_d.confirmed = level && s_q.first; // [R8]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign confirmed = s_q.confirmed;

	// =============================================================
	// checks
	level_twice_a: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
		$rose(s_q.confirmed) |-> $past(tick) && $past(level)
			&& $past(s_q.first))
		else $error("wake confirmed without two samples at level");

endmodule

// ### hdl/scs_sleep_ctrl.sv
`timescale 1ns/1ps
// Function
// R1 - sleep entered only if permit bit set and sleep instruction executes
// R2 - enabled interrupt wakes core; it resumes after sleep, state kept
// R3 - reset while asleep wakes core and starts at reset vector
// R4 - kind 00 is Idle: only the CPU stops, peripherals keep running
// R5 - wake from Idle resumes execution at once, no delay
// R6 - kind 10 is Power-down: oscillator stops, ext irq and watchdog run
// R7 - Power-down wakes only on ext reset, watchdog reset or level irq
// R8 - level irq sampled twice on watchdog clock, both must match
// R9 - Power-down wake waits the fuse-selected restart delay
// R10 - wake cause gone before execution resumes: its interrupt is dropped
// R11 - kind 11 is Power-save: like Power-down but async timer0 runs
// R12 - Power-save also wakes on enabled timer0 overflow or compare
// R13 - software must set global interrupt enable to run the routine
// R14 - Power-save wake holds flag updates two or three cycles
// R15 - software uses Power-down when timer0 is not async clocked
// R16 - timer0 prescaler source is system clock, or osc pin if selected
// R17 - undefined kind 01 behaves as Idle
module scs_sleep_ctrl
	import scs_pkg::*;
#(
	parameter int unsigned RESTART_US_0 = 1,
	parameter int unsigned RESTART_US_1 = 100,
	parameter int unsigned RESTART_US_2 = 1000,
	parameter int unsigned RESTART_US_3 = 16000
)
(
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output      logic [31:0] HRDATA,
	output      logic        HREADYOUT,
	output      logic        HRESP,
	output      logic        IRQ,
	input  wire logic        SLEEP_EXEC,
	input  wire logic        IRQ_REQ,
	input  wire logic        EXT_RESET,
	input  wire logic        WDT_RESET,
	input  wire logic        LEVEL_IRQ,
	input  wire logic        WDT_OSC_TICK,
	input  wire logic        T0_OVF,
	input  wire logic        T0_CMP,
	input  wire logic        TIMER_OSC_IN_PIN,
	output      logic        CPU_RUN,
	output      logic        OSC_RUN,
	output      logic        PERIPH_RUN,
	output      logic        T0_RUN,
	output      logic        TIMER0_PRESCALER_SOURCE,
	output      logic        FLAG_HOLD,
	output      logic        WAKE_RESUME,
	output      logic        WAKE_VECTOR,
	output      logic        WAKE_DISCARD
);

	// =============================================================
	// restart delay per fuse setting, rounded up to whole cycles
	localparam int unsigned CYC_0 =
		(RESTART_US_0 * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CYC_1 =
		(RESTART_US_1 * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CYC_2 =
		(RESTART_US_2 * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CYC_3 =
		(RESTART_US_3 * NS_PER_US + CLK_NS - 1) / CLK_NS;

	function automatic logic [DELAY_W-1:0] restart_cycles(
		input logic [1:0] fuse
	);
		case (fuse)
			2'h0:    restart_cycles = DELAY_W'(CYC_0);
			2'h1:    restart_cycles = DELAY_W'(CYC_1);
			2'h2:    restart_cycles = DELAY_W'(CYC_2);
			default: restart_cycles = DELAY_W'(CYC_3);
		endcase
	endfunction

	function automatic logic [1:0] sleep_kind(input scs_ctrl_type c);
		logic [1:0] k;
		k = {c.sleep_kind_select_hi, c.sleep_kind_select_lo};
		// the undefined code falls back to the lightest sleep
		sleep_kind = (k == KIND_UNDEF) ? KIND_IDLE : k; // [R17]
	endfunction

	scs_state_type q;
	scs_state_type d;
	scs_event_type ev;
	scs_event_type clr;
	logic          any_reset;
	logic          level_ok;
	logic          timer_wake;

	scs_level_sampler u_sampler (
		.clk       (MCLK),
		.rst_n     (RST_N),
		.armed     (q.mode == MODE_DOWN),
		.level     (LEVEL_IRQ),
		.tick      (WDT_OSC_TICK),
		.confirmed (level_ok)
	);

	assign any_reset  = EXT_RESET || WDT_RESET;
	// timer0 only counts in Power-save when it runs off its own oscillator
	assign timer_wake = q.saving && q.ctrl.timer0_external_osc_select
		&& ((T0_OVF && q.ctrl.t0_ovf_irq_en)
		|| (T0_CMP && q.ctrl.t0_cmp_irq_en)); // [R11] [R12]

	// =============================================================
	// sleep sequencer and register file
	always_comb begin
		d         = q;
		ev        = EVENT_NONE;
		clr       = EVENT_NONE;
		d.resume  = 1'b0;
		d.vector  = 1'b0;
		d.discard = 1'b0;
		case (q.mode)
			MODE_RUN: begin
				if (SLEEP_EXEC && q.ctrl.sleep_permit_bit) begin // [R1]
					ev.slept     = 1'b1;
					d.cause      = CAUSE_NONE;
					d.level_lost = 1'b0;
					d.saving     = sleep_kind(q.ctrl) == KIND_SAVE;
					if (sleep_kind(q.ctrl) == KIND_IDLE) begin // [R4]
						d.mode = MODE_IDLE;
					end else begin
						d.mode = MODE_DOWN; // [R6] [R11]
					end
				end
			end
			MODE_IDLE: begin
				if (any_reset) begin
					d.mode        = MODE_RUN;
					d.vector      = 1'b1; // [R3]
					ev.reset_wake = 1'b1;
				end else if (IRQ_REQ) begin
					d.mode   = MODE_RUN; // [R5]
					d.resume = 1'b1; // [R2]
					ev.woke  = 1'b1;
				end
			end
			MODE_DOWN: begin
				// anything else, idle interrupts included, is ignored
				if (any_reset || level_ok || timer_wake) begin // [R7]
					d.mode = MODE_RESTART;
					d.dly  = restart_cycles(q.ctrl.startup_time_fuses)
						- DELAY_ONE; // [R9]
					if (any_reset) begin
						d.cause = CAUSE_RESET;
					end else if (level_ok) begin
						d.cause = CAUSE_LEVEL;
					end else begin
						d.cause = CAUSE_TIMER;
					end
				end
			end
			MODE_RESTART: begin
				if (q.cause == CAUSE_LEVEL && !LEVEL_IRQ) begin
					d.level_lost = 1'b1; // [R10]
				end
				if (q.dly != '0) begin
					d.dly = q.dly - DELAY_ONE; // [R9]
				end else if (q.cause == CAUSE_RESET) begin
					d.mode        = MODE_RUN;
					d.vector      = 1'b1; // [R3]
					ev.reset_wake = 1'b1;
				end else if (d.level_lost) begin
					d.mode          = MODE_RUN;
					d.discard       = 1'b1; // [R10]
					ev.wake_dropped = 1'b1;
				end else begin
					d.resume = 1'b1; // [R2]
					ev.woke  = 1'b1;
					if (q.saving) begin
						d.mode   = MODE_SETTLE;
						d.settle = (q.cause == CAUSE_TIMER)
							? SETTLE_TIMER_CYC - SETTLE_ONE
							: SETTLE_EXT_CYC - SETTLE_ONE; // [R14]
					end else begin
						d.mode = MODE_RUN;
					end
				end
			end
			MODE_SETTLE: begin
				if (q.settle == '0) begin
					d.mode = MODE_RUN;
				end else begin
					d.settle = q.settle - SETTLE_ONE; // [R14]
				end
			end
			default: begin
				d.mode = MODE_RUN;
			end
		endcase

		// bus data phase: write into the addressed register
		if (q.a_valid && q.a_write) begin
			if (q.a_addr == ADDR_CTRL) begin
				d.ctrl = HWDATA[$bits(scs_ctrl_type)-1:0];
			end else if (q.a_addr == ADDR_STATUS) begin
				clr = HWDATA[$bits(scs_event_type)-1:0];
			end else if (q.a_addr == ADDR_MASK) begin
				d.mask = HWDATA[$bits(scs_event_type)-1:0];
			end
		end
		// a new event beats a clear written in the same cycle
		d.status = (q.status & ~clr) | ev;

		// bus address phase; read data is taken from the updated copy so
		// a read right behind a write sees the written value
		if (HREADY) begin
			d.a_valid = HSEL && HTRANS[1];
			d.a_write = HWRITE;
			d.a_addr  = HADDR;
			d.rdata   = RDATA_ZERO;
			if (HSEL && HTRANS[1] && !HWRITE) begin
				if (HADDR == ADDR_CTRL) begin
					d.rdata = 32'(d.ctrl);
				end else if (HADDR == ADDR_STATUS) begin
					d.rdata = 32'(d.status);
				end else if (HADDR == ADDR_MASK) begin
					d.rdata = 32'(d.mask);
				end else if (HADDR == ADDR_STATE) begin
					d.rdata = 32'({q.saving, q.cause, q.mode});
				end
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			q        <= '0;
			q.mode   <= MODE_RUN;
			q.cause  <= CAUSE_NONE;
			q.ctrl   <= CTRL_RESET;
			q.status <= EVENT_NONE;
			q.mask   <= EVENT_NONE;
		end else begin
			q <= d;
		end
	end

	// =============================================================
	// outputs
	assign HRDATA    = q.rdata;
	assign HREADYOUT = 1'b1;
	assign HRESP     = HRESP_OKAY;
	assign IRQ       = |(q.status & q.mask);

	assign CPU_RUN    = (q.mode == MODE_RUN) || (q.mode == MODE_SETTLE);
	assign OSC_RUN    = q.mode != MODE_DOWN; // [R6]
	assign PERIPH_RUN = (q.mode != MODE_DOWN)
		&& (q.mode != MODE_RESTART); // [R4]
	assign T0_RUN     = PERIPH_RUN || (q.saving
		&& q.ctrl.timer0_external_osc_select); // [R11]
	// plain clock mux; the select must only change while timer0 is stopped
	assign TIMER0_PRESCALER_SOURCE = q.ctrl.timer0_external_osc_select
		? TIMER_OSC_IN_PIN : MCLK; // [R16]
	assign FLAG_HOLD    = q.mode == MODE_SETTLE; // [R14]
	assign WAKE_RESUME  = q.resume;
	assign WAKE_VECTOR  = q.vector;
	assign WAKE_DISCARD = q.discard;

	// =============================================================
	// checks
	logic [DELAY_W-1:0] restart_seen;

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			restart_seen <= '0;
		end else if (q.mode == MODE_RESTART) begin
			restart_seen <= restart_seen + DELAY_ONE;
		end else if (d.mode == MODE_RESTART) begin
			restart_seen <= '0;
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	permit_needed_a: assert property ( // [R1]
		q.mode == MODE_RUN && SLEEP_EXEC && !q.ctrl.sleep_permit_bit
		|=> q.mode == MODE_RUN)
		else $error("sleep entered without permit");
	idle_wake_a: assert property ( // [R5]
		q.mode == MODE_IDLE && IRQ_REQ && !any_reset
		|=> WAKE_RESUME && CPU_RUN)
		else $error("idle wake not immediate");
	reset_vector_a: assert property ( // [R3]
		q.mode == MODE_IDLE && any_reset |=> WAKE_VECTOR && !WAKE_RESUME)
		else $error("reset wake did not go to vector");
	idle_keeps_a: assert property ( // [R4]
		q.mode == MODE_IDLE |-> PERIPH_RUN && OSC_RUN && !CPU_RUN)
		else $error("idle stopped more than the cpu");
	down_deaf_a: assert property ( // [R7]
		q.mode == MODE_DOWN && !any_reset && !level_ok && !timer_wake
		|=> q.mode == MODE_DOWN && !OSC_RUN)
		else $error("power-down left without a wake source");
	restart_len_a: assert property ( // [R9]
		$past(q.mode) == MODE_RESTART && q.mode != MODE_RESTART
		|-> restart_seen == restart_cycles(q.ctrl.startup_time_fuses))
		else $error("restart delay has wrong length");
	lost_drop_a: assert property ( // [R10]
		WAKE_RESUME && q.cause == CAUSE_LEVEL |-> !q.level_lost)
		else $error("dropped level wake still resumed");
	timer_wake_a: assert property ( // [R12]
		q.mode == MODE_DOWN && timer_wake && !any_reset && !level_ok
		|=> q.mode == MODE_RESTART && q.cause == CAUSE_TIMER)
		else $error("timer0 event did not wake power-save");
	save_timer_a: assert property ( // [R11]
		q.mode == MODE_DOWN && q.saving
		&& q.ctrl.timer0_external_osc_select |-> T0_RUN && !PERIPH_RUN)
		else $error("async timer0 stopped in power-save");
	settle_timer_a: assert property ( // [R14]
		$rose(FLAG_HOLD) && q.cause == CAUSE_TIMER
		|-> FLAG_HOLD [*3] ##1 !FLAG_HOLD)
		else $error("timer wake flag hold not three cycles");
	settle_ext_a: assert property ( // [R14]
		$rose(FLAG_HOLD) && q.cause == CAUSE_LEVEL
		|-> FLAG_HOLD [*2] ##1 !FLAG_HOLD)
		else $error("external wake flag hold not two cycles");
	undef_idle_a: assert property ( // [R17]
		q.mode == MODE_RUN && SLEEP_EXEC && q.ctrl.sleep_permit_bit
		&& {q.ctrl.sleep_kind_select_hi, q.ctrl.sleep_kind_select_lo}
		== KIND_UNDEF |=> q.mode == MODE_IDLE)
		else $error("undefined kind did not act as idle");

	idle_cycle_c: cover property (
		q.mode == MODE_IDLE ##1 WAKE_RESUME);
	down_level_c: cover property (
		q.mode == MODE_RESTART && q.cause == CAUSE_LEVEL ##[1:300]
		WAKE_RESUME);
	save_timer_c: cover property ($rose(FLAG_HOLD)
		&& q.cause == CAUSE_TIMER);
	dropped_c: cover property (WAKE_DISCARD);

endmodule

// ### dv/scs_src_model.sv
`timescale 1ns/1ps
module scs_src_model #(
	parameter int unsigned TICK_CYC = 10
)
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic t0_run,
	input  wire logic fire_ovf,
	input  wire logic fire_cmp,
	output      logic wdt_tick,
	output      logic t0_ovf,
	output      logic t0_cmp
);
	// =============================================================
	// watchdog oscillator runs free, also while the core sleeps
	int unsigned cnt;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt      <= 0;
			wdt_tick <= 1'b0;
		end else begin
			cnt      <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
			wdt_tick <= (cnt == TICK_CYC - 1);
		end
	end

	// =============================================================
	// a stopped timer0 raises no event, so events need its clock
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			t0_ovf <= 1'b0;
			t0_cmp <= 1'b0;
		end else begin
			t0_ovf <= fire_ovf & t0_run;
			t0_cmp <= fire_cmp & t0_run;
		end
	end
endmodule

// ### dv/tb_scs_sleep_ctrl.sv
`timescale 1ns/1ps
module tb_scs_sleep_ctrl;
	import scs_pkg::*;
	localparam int TICK = 10;
	localparam int RST_CYC = 1 * NS_PER_US / CLK_NS;
	logic        MCLK, RST_N, HSEL, HWRITE, SLEEP_EXEC, IRQ_REQ;
	logic        EXT_RESET, WDT_RESET, LEVEL_IRQ, TIMER_OSC_IN_PIN;
	logic        fire_ovf, fire_cmp, HREADYOUT, HRESP, IRQ;
	logic        CPU_RUN, OSC_RUN, PERIPH_RUN, T0_RUN, FLAG_HOLD;
	logic        TIMER0_PRESCALER_SOURCE, WAKE_RESUME;
	logic        WAKE_VECTOR, WAKE_DISCARD, WDT_OSC_TICK, T0_OVF, T0_CMP;
	logic [1:0]  HTRANS;
	logic [2:0]  HSIZE;
	logic [2:0]  w;
	logic [31:0] HADDR, HWDATA, HRDATA, rdata;
	wire  logic  HREADY;
	int          num_errors, check_count, n;

	assign HREADY = HREADYOUT;

	// short restart delays so that every fuse setting fits in the run
	scs_sleep_ctrl #(.RESTART_US_0(1), .RESTART_US_1(2), .RESTART_US_2(3),
		.RESTART_US_3(4)) dut (.MCLK(MCLK), .RST_N(RST_N),
		.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
		.HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ),
		.SLEEP_EXEC(SLEEP_EXEC), .IRQ_REQ(IRQ_REQ), .EXT_RESET(EXT_RESET),
		.WDT_RESET(WDT_RESET), .LEVEL_IRQ(LEVEL_IRQ),
		.WDT_OSC_TICK(WDT_OSC_TICK), .T0_OVF(T0_OVF), .T0_CMP(T0_CMP),
		.TIMER_OSC_IN_PIN(TIMER_OSC_IN_PIN), .CPU_RUN(CPU_RUN),
		.OSC_RUN(OSC_RUN), .PERIPH_RUN(PERIPH_RUN), .T0_RUN(T0_RUN),
		.TIMER0_PRESCALER_SOURCE(TIMER0_PRESCALER_SOURCE),
		.FLAG_HOLD(FLAG_HOLD), .WAKE_RESUME(WAKE_RESUME),
		.WAKE_VECTOR(WAKE_VECTOR), .WAKE_DISCARD(WAKE_DISCARD));

	scs_src_model #(.TICK_CYC(TICK)) src (.clk(MCLK), .rst_n(RST_N),
		.t0_run(T0_RUN), .fire_ovf(fire_ovf), .fire_cmp(fire_cmp),
		.wdt_tick(WDT_OSC_TICK), .t0_ovf(T0_OVF), .t0_cmp(T0_CMP));

	// =============================================================
	// helpers
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task cyc(input int c);
		repeat (c) @(posedge MCLK);
	endtask

	task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		HSEL   <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= wr;
		HADDR  <= a;
		HSIZE  <= 3'h2;
		do @(posedge MCLK); while (HREADY !== 1'b1);
		HSEL   <= 1'b0;
		HTRANS <= HTRANS_IDLE;
		HWDATA <= wd;
		do @(posedge MCLK); while (HREADY !== 1'b1);
		rdata = HRDATA;
	endtask

	task sleep_now();
		SLEEP_EXEC <= 1'b1;
		cyc(1);
		SLEEP_EXEC <= 1'b0;
		#1;
	endtask

	// w = {vector, discard, resume}; n = cycles waited
	task wait_wake();
		n = 0;
		w = 3'h0;
		while (w === 3'h0 && n < 100) begin
			cyc(1);
			#1;
			w = {WAKE_VECTOR, WAKE_DISCARD, WAKE_RESUME};
			n++;
		end
	endtask

	task final_report();
		if (num_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// =============================================================
	// scenarios
	task t_reset();
		for (int a = 0; a < 5; a++) begin
			bus(1'b0, a * 4, 32'h0);
			chk(rdata, RDATA_ZERO);
		end
		chk({CPU_RUN, OSC_RUN, PERIPH_RUN, T0_RUN, FLAG_HOLD, IRQ, HRESP,
			HREADYOUT}, 8'hF1);
	endtask

	task t_permit();
		bus(1'b1, ADDR_CTRL, 32'h0000_0006);
		sleep_now();
		chk(CPU_RUN, 1'b1);
		bus(1'b0, ADDR_STATE, 32'h0);
		chk(rdata[2:0], MODE_RUN);
	endtask

	task t_idle();
		for (int k = 0; k < 2; k++) begin
			bus(1'b1, ADDR_CTRL, (k << 1) | 1);
			sleep_now();
			chk({CPU_RUN, OSC_RUN, PERIPH_RUN}, 3'h3);
			if (k == 0)
				IRQ_REQ <= 1'b1;
			else
				EXT_RESET <= 1'b1;
			wait_wake();
			chk(w, (k == 0) ? 3'h1 : 3'h4);
			chk(n <= 2, 1'b1);
			chk(CPU_RUN, 1'b1);
			IRQ_REQ   <= 1'b0;
			EXT_RESET <= 1'b0;
		end
	endtask

	task t_down();
		bus(1'b1, ADDR_CTRL, 32'h0000_0005);
		sleep_now();
		chk({CPU_RUN, OSC_RUN, PERIPH_RUN, T0_RUN}, 4'h0);
		IRQ_REQ  <= 1'b1;
		fire_ovf <= 1'b1;
		cyc(1);
		fire_ovf  <= 1'b0;
		// too short to span two watchdog samples
		LEVEL_IRQ <= 1'b1;
		cyc(5);
		LEVEL_IRQ <= 1'b0;
		cyc(30);
		#1;
		chk(CPU_RUN, 1'b0);
		IRQ_REQ   <= 1'b0;
		LEVEL_IRQ <= 1'b1;
		wait_wake();
		chk(w, 3'h1);
		chk(n >= RST_CYC + TICK && n <= 2 * TICK + RST_CYC + 6, 1'b1);
		chk({CPU_RUN, FLAG_HOLD}, 2'h2);
		LEVEL_IRQ <= 1'b0;
	endtask

	task t_drop();
		bus(1'b1, ADDR_CTRL, 32'h0000_0005);
		sleep_now();
		LEVEL_IRQ <= 1'b1;
		n = 0;
		do begin
			bus(1'b0, ADDR_STATE, 32'h0);
			n++;
		end while (rdata[2:0] !== MODE_RESTART && n < 40);
		LEVEL_IRQ <= 1'b0;
		wait_wake();
		chk(w, 3'h2);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(rdata[2], 1'b1);
	endtask

	task t_rst_wake();
		// one pass per fuse setting; fuse k restarts after k+1 us
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, ADDR_CTRL, 32'h0000_0005 | (i << 6));
			sleep_now();
			if (i[0] == 1'b0)
				EXT_RESET <= 1'b1;
			else
				WDT_RESET <= 1'b1;
			wait_wake();
			chk(w, 3'h4);
			chk(n, 1 + (i + 1) * NS_PER_US / CLK_NS);
			EXT_RESET <= 1'b0;
			WDT_RESET <= 1'b0;
		end
	endtask

	// async select stays set in Power-save; the routine itself is gated
	// by the core's global enable, which this block never sees
	task t_save();
		int h;
		for (int j = 0; j < 3; j++) begin
			bus(1'b1, ADDR_CTRL,
				(j == 0) ? 32'h1F : (j == 1) ? 32'h2F : 32'h0F);
			sleep_now();
			chk({OSC_RUN, T0_RUN}, 2'h1);
			fire_ovf <= (j != 1);
			fire_cmp <= (j == 1);
			cyc(1);
			fire_ovf <= 1'b0;
			fire_cmp <= 1'b0;
			if (j == 2) begin
				cyc(5);
				#1;
				chk(CPU_RUN, 1'b0);
				LEVEL_IRQ <= 1'b1;
			end
			wait_wake();
			chk(w, 3'h1);
			h = 0;
			while (FLAG_HOLD === 1'b1 && h < 10) begin
				h++;
				cyc(1);
				#1;
			end
			chk(h, (j == 2) ? 2 : 3);
			LEVEL_IRQ <= 1'b0;
		end
	endtask

	task t_irq();
		bus(1'b1, ADDR_MASK, 32'h0);
		cyc(1);
		chk(IRQ, 1'b0);
		bus(1'b1, ADDR_MASK, 32'h2);
		cyc(1);
		chk(IRQ, 1'b1);
		bus(1'b1, ADDR_STATUS, 32'h2);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(rdata[1], 1'b0);
		chk(IRQ, 1'b0);
		bus(1'b0, ADDR_MASK, 32'h0);
		chk(rdata, 32'h2);
		bus(1'b1, ADDR_STATUS, 32'hF);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(rdata, 32'h0);
	endtask

	task t_presc();
		bus(1'b1, ADDR_CTRL, 32'h8);
		for (int p = 0; p < 2; p++) begin
			TIMER_OSC_IN_PIN <= p[0];
			cyc(1);
			#60;
			chk(TIMER0_PRESCALER_SOURCE, p[0]);
		end
		bus(1'b1, ADDR_CTRL, 32'h0);
		#1;
		chk(TIMER0_PRESCALER_SOURCE, 1'b1);
		#50;
		chk(TIMER0_PRESCALER_SOURCE, 1'b0);
	endtask

	// =============================================================
	// clock, sequence, watchdog
	initial begin
		MCLK = 1'b0;
		forever #50 MCLK = ~MCLK;
	end

	initial begin
		{RST_N, HSEL, HWRITE, SLEEP_EXEC, IRQ_REQ, EXT_RESET} = '0;
		{WDT_RESET, LEVEL_IRQ, TIMER_OSC_IN_PIN, fire_ovf, fire_cmp} = '0;
		HTRANS = HTRANS_IDLE;
		HSIZE  = 3'h2;
		HADDR  = 32'h0;
		HWDATA = 32'h0;
		num_errors  = 0;
		check_count = 0;
		cyc(5);
		RST_N <= 1'b1;
		cyc(1);
		t_reset();
		t_permit();
		t_idle();
		t_down();
		t_drop();
		t_rst_wake();
		t_save();
		t_irq();
		t_presc();
		final_report();
	end

	initial begin
		cyc(5000);
		num_errors++;
		final_report();
	end
endmodule
